//--- logic/port_pin_function_mux.v
// pin function multiplexer for interrupt pins and ports K, AD, M, P, Q
`include "pin_mux_map.vh"

module port_pin_function_mux #(
  parameter AD_WIDTH = 16
) (
  input  wire                sys_clk,
  input  wire                sys_rst,
  // interrupt pins and cpu masks
  input  wire                maskable_int_pin_n,
  input  wire                nonmaskable_int_pin_n,
  input  wire                edge_trigger_select_wr,
  input  wire                edge_trigger_select_in,
  input  wire                maskable_int_enable_wr,
  input  wire                maskable_int_enable_in,
  input  wire                cpu_clear_i_mask,
  input  wire                cpu_clear_x_mask,
  output reg                 port_e_in_q,
  output reg                 port_e_in0_q,
  output reg                 maskable_int_req_q,
  output reg                 nonmaskable_int_req_q,
  output reg                 i_mask_q,
  output reg                 x_mask_q,
  // pull-up control
  input  wire                port_e_pullup_enable_wr,
  input  wire                port_e_pullup_enable_in,
  input  wire                port_k_pullup_enable_wr,
  input  wire                port_k_pullup_enable_in,
  output reg                 port_e_pullup_q,
  output reg  [7:0]          port_k_pullup_q,
  // port K and external bus
  input  wire                expanded_mode,
  input  wire                port_k_emulation_enable,
  input  wire                emulation_chip_select_n,
  input  wire                external_chip_select_n,
  input  wire [19:14]        extended_address,
  input  wire [7:0]          port_k_in,
  input  wire [7:0]          port_k_data,
  input  wire [7:0]          port_k_dir,
  output reg  [7:0]          port_k_out_q,
  output reg  [7:0]          port_k_oe_q,
  output reg  [7:0]          port_k_read_q,
  output reg                 onchip_rom_enable_q,
  // port AD keypad wake-up
  input  wire [AD_WIDTH-1:0] port_ad_in,
  input  wire [AD_WIDTH-1:0] port_ad_digital_en,
  input  wire [AD_WIDTH-1:0] keypad_wakeup_analog_port_en,
  input  wire [AD_WIDTH-1:0] keypad_wakeup_clear,
  output wire [AD_WIDTH-1:0] keypad_wakeup_flag,
  output wire                keypad_wakeup_irq,
  // port M
  input  wire [7:0]          port_m_in,
  input  wire [7:0]          port_m_data,
  input  wire [7:0]          port_m_dir,
  input  wire                i2c_enable,
  input  wire                i2c_scl_oe,
  input  wire                i2c_sda_oe,
  input  wire                uart_two_tx_enable,
  input  wire                uart_two_transmit,
  input  wire                uart_two_rx_enable,
  input  wire                dac_one_enable,
  input  wire                dac_two_enable,
  output reg  [7:0]          port_m_out_q,
  output reg  [7:0]          port_m_oe_q,
  output reg                 i2c_scl_in_q,
  output reg                 i2c_sda_in_q,
  output reg                 uart_two_receive_q,
  output reg                 dac_output_one_sel_q,
  output reg                 dac_output_two_sel_q,
  // port P and Q
  input  wire                fault_pwm_unit_enable,
  input  wire [2:0]          fault_pwm_pair_enable,
  input  wire [5:0]          fault_pwm_outputs,
  input  wire                current_status_enable,
  input  wire                fault_input_enable,
  input  wire [5:0]          port_p_data,
  input  wire [5:0]          port_p_dir,
  input  wire [6:0]          port_q_in,
  input  wire [6:0]          port_q_data,
  input  wire [6:0]          port_q_dir,
  output reg  [5:0]          port_p_out_q,
  output reg  [5:0]          port_p_oe_q,
  output reg  [6:0]          port_q_out_q,
  output reg  [6:0]          port_q_oe_q,
  output reg  [2:0]          current_status_inputs_q,
  output reg  [3:0]          fault_inputs_q
);
  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  reg  [1:0] int_pin_control_reg_q;
  reg  [1:0] pullup_control_reg_q;
  reg        rst_seen_q;
  reg        irq_prev_q;
  wire       edge_mode;
  wire       irq_enabled;
  wire       irq_event;
  wire       emk_active;
  wire [5:0] pair_sel;
  // mask bits come up from the condition code reset pattern
  localparam [1:0] CCR_INIT = `CCR_RESET;

  assign edge_mode   = int_pin_control_reg_q[`IPC_EDGE_BIT];
  assign irq_enabled = int_pin_control_reg_q[`IPC_ENABLE_BIT];
  assign emk_active  = expanded_mode & port_k_emulation_enable;
  assign pair_sel    = pwm_claim(fault_pwm_unit_enable, fault_pwm_pair_enable);
  // falling edge or low level
  assign irq_event   = edge_mode ? (irq_prev_q & ~maskable_int_pin_n)
                                 : ~maskable_int_pin_n;

  // per-pin mux: peripheral claim wins over general port
  function sel_bit;
    input claim;
    input periph;
    input gp;
    begin
      sel_bit = claim ? periph : gp;
    end
  endfunction

  // pwm claim per port P bit, pair n owns bits 2n+1 and 2n
  function [5:0] pwm_claim;
    input       unit_en;
    input [2:0] pairs;
    begin
      pwm_claim = {6{unit_en}} & {{2{pairs[2]}}, {2{pairs[1]}}, {2{pairs[0]}}};
    end
  endfunction

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_pin_control_reg_q <= `IPC_RESET;
      pullup_control_reg_q  <= `PUC_RESET;
      i_mask_q              <= CCR_INIT[`CCR_I_BIT];
      x_mask_q              <= CCR_INIT[`CCR_X_BIT];
      rst_seen_q            <= 1'b1;
      onchip_rom_enable_q   <= 1'b0;
    end else begin
      if (edge_trigger_select_wr)
        int_pin_control_reg_q[`IPC_EDGE_BIT] <= edge_trigger_select_in;
      if (maskable_int_enable_wr)
        int_pin_control_reg_q[`IPC_ENABLE_BIT] <= maskable_int_enable_in;
      if (port_e_pullup_enable_wr)
        pullup_control_reg_q[`PUC_PORT_E_BIT] <= port_e_pullup_enable_in;
      if (port_k_pullup_enable_wr)
        pullup_control_reg_q[`PUC_PORT_K_BIT] <= port_k_pullup_enable_in;
      if (cpu_clear_i_mask)
        i_mask_q <= 1'b0;
      if (cpu_clear_x_mask)
        x_mask_q <= 1'b0;
      // first edge after release latches rom enable from K7 in expanded mode
      rst_seen_q <= 1'b0;
      if (rst_seen_q && expanded_mode)
        onchip_rom_enable_q <= port_k_in[`PK_ECS_BIT];
    end
  end

  // ----------------------------------------------------------------
  // pin levels and interrupt requests
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_prev_q            <= 1'b1;
      port_e_in_q           <= 1'b1;
      port_e_in0_q          <= 1'b1;
      maskable_int_req_q    <= 1'b0;
      nonmaskable_int_req_q <= 1'b0;
    end else begin
      irq_prev_q            <= maskable_int_pin_n;
      port_e_in_q           <= maskable_int_pin_n;
      port_e_in0_q          <= nonmaskable_int_pin_n;
      maskable_int_req_q    <= irq_event & irq_enabled & ~i_mask_q;
      nonmaskable_int_req_q <= ~nonmaskable_int_pin_n & ~x_mask_q;
    end
  end

  // ----------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_e_pullup_q         <= 1'b1;
      port_k_pullup_q         <= 8'hff;
      port_k_out_q            <= 8'h00;
      port_k_oe_q             <= 8'h00;
      port_k_read_q           <= 8'hff;
    end else begin
      port_e_pullup_q <= pullup_control_reg_q[`PUC_PORT_E_BIT];
      port_k_pullup_q <= {8{pullup_control_reg_q[`PUC_PORT_K_BIT]}} & ~port_k_oe_q;
      port_k_read_q   <= port_k_in;
      // port K: emulation bus functions
      port_k_out_q[`PK_ECS_BIT] <= sel_bit(emk_active, emulation_chip_select_n,
                                           port_k_data[`PK_ECS_BIT]);
      port_k_oe_q[`PK_ECS_BIT]  <= emk_active | port_k_dir[`PK_ECS_BIT];
      port_k_out_q[`PK_XCS_BIT] <= sel_bit(emk_active, external_chip_select_n,
                                           port_k_data[`PK_XCS_BIT]);
      port_k_oe_q[`PK_XCS_BIT]  <= emk_active | port_k_dir[`PK_XCS_BIT];
      port_k_out_q[`PK_ADDR_HI:0] <= emk_active ? extended_address[`EXTENDED_ADDRESS_HI:`EXTENDED_ADDRESS_LO]
                                                : port_k_data[`PK_ADDR_HI:0];
      port_k_oe_q[`PK_ADDR_HI:0]  <= {6{emk_active}} | port_k_dir[`PK_ADDR_HI:0];
    end
  end

  // ----------------------------------------------------------------
  // port M routing
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_m_out_q            <= 8'h00;
      port_m_oe_q             <= 8'h00;
      i2c_scl_in_q            <= 1'b1;
      i2c_sda_in_q            <= 1'b1;
      uart_two_receive_q      <= 1'b1;
      dac_output_one_sel_q    <= 1'b0;
      dac_output_two_sel_q    <= 1'b0;
    end else begin
      // port M: general port first, then peripheral claims
      port_m_out_q <= port_m_data;
      port_m_oe_q  <= port_m_dir;
      if (i2c_enable) begin
        port_m_out_q[`PM_SCL_BIT] <= 1'b0;
        port_m_oe_q[`PM_SCL_BIT]  <= i2c_scl_oe;
        port_m_out_q[`PM_SDA_BIT] <= 1'b0;
        port_m_oe_q[`PM_SDA_BIT]  <= i2c_sda_oe;
      end
      if (uart_two_tx_enable) begin
        port_m_out_q[`PM_TX_BIT] <= uart_two_transmit;
        port_m_oe_q[`PM_TX_BIT]  <= 1'b1;
      end
      if (uart_two_rx_enable)
        port_m_oe_q[`PM_RX_BIT] <= 1'b0;
      if (dac_one_enable)
        port_m_oe_q[`PM_DAC1_BIT] <= 1'b0;
      if (dac_two_enable)
        port_m_oe_q[`PM_DAC2_BIT] <= 1'b0;
      i2c_scl_in_q         <= i2c_enable ? port_m_in[`PM_SCL_BIT] : 1'b1;
      i2c_sda_in_q         <= i2c_enable ? port_m_in[`PM_SDA_BIT] : 1'b1;
      uart_two_receive_q   <= uart_two_rx_enable ? port_m_in[`PM_RX_BIT] : 1'b1;
      dac_output_one_sel_q <= dac_one_enable;
      dac_output_two_sel_q <= dac_two_enable;
    end
  end

  // ----------------------------------------------------------------
  // ports P and Q routing
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_p_out_q            <= 6'h00;
      port_p_oe_q             <= 6'h00;
      port_q_out_q            <= 7'h00;
      port_q_oe_q             <= 7'h00;
      current_status_inputs_q <= 3'h7;
      fault_inputs_q          <= 4'h0;
    end else begin
      // port P: pwm outputs per pair
      port_p_out_q <= (pair_sel & fault_pwm_outputs) | (~pair_sel & port_p_data);
      port_p_oe_q  <= pair_sel | port_p_dir;
      // port Q: status and fault inputs force input direction
      port_q_out_q <= port_q_data;
      port_q_oe_q[`PQ_IS_HI:`PQ_IS_LO] <= current_status_enable ? 3'h0
                                          : port_q_dir[`PQ_IS_HI:`PQ_IS_LO];
      port_q_oe_q[`PQ_FAULT_HI:0]      <= fault_input_enable ? 4'h0
                                          : port_q_dir[`PQ_FAULT_HI:0];
      current_status_inputs_q <= current_status_enable ?
                                 port_q_in[`PQ_IS_HI:`PQ_IS_LO] : 3'h7;
      fault_inputs_q          <= fault_input_enable ?
                                 port_q_in[`PQ_FAULT_HI:0] : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // keypad wake-up
  // ----------------------------------------------------------------
  wake_detect #(
    .WIDTH (AD_WIDTH)
  ) u_wake (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .pin_in      (port_ad_in),
    .digital_en  (port_ad_digital_en),
    .wake_en     (keypad_wakeup_analog_port_en),
    .wake_clear  (keypad_wakeup_clear),
    .wake_flag_q (keypad_wakeup_flag),
    .wake_irq_q  (keypad_wakeup_irq)
  );
endmodule // port_pin_function_mux

//--- logic/pin_mux_map.vh
// constants for the port pin function multiplexer
`ifndef PIN_MUX_MAP_VH
`define PIN_MUX_MAP_VH
// ----------------------------------------------------------------
// interrupt pin control register fields
// ----------------------------------------------------------------
`define IPC_EDGE_BIT        1
`define IPC_ENABLE_BIT      0
`define IPC_RESET           2'h1
// ----------------------------------------------------------------
// pull-up control register fields
// ----------------------------------------------------------------
`define PUC_PORT_E_BIT      1
`define PUC_PORT_K_BIT      0
`define PUC_RESET           2'h3
// ----------------------------------------------------------------
// condition code mask fields
// ----------------------------------------------------------------
`define CCR_X_BIT           1
`define CCR_I_BIT           0
`define CCR_RESET           2'h3
// ----------------------------------------------------------------
// port K layout
// ----------------------------------------------------------------
`define PK_ECS_BIT          7
`define PK_XCS_BIT          6
`define PK_ADDR_HI          5
`define EXTENDED_ADDRESS_HI            19
`define EXTENDED_ADDRESS_LO            14
// ----------------------------------------------------------------
// port M layout
// ----------------------------------------------------------------
`define PM_SCL_BIT          7
`define PM_SDA_BIT          6
`define PM_TX_BIT           5
`define PM_RX_BIT           4
`define PM_DAC1_BIT         1
`define PM_DAC2_BIT         0
// ----------------------------------------------------------------
// port Q layout
// ----------------------------------------------------------------
`define PQ_IS_LO            4
`define PQ_IS_HI            6
`define PQ_FAULT_HI         3
`endif

//--- logic/wake_detect.v
// keypad wake-up edge detector for the analog port pins
module wake_detect #(
  parameter WIDTH = 16
) (
  input  wire             sys_clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] pin_in,
  input  wire [WIDTH-1:0] digital_en,
  input  wire [WIDTH-1:0] wake_en,
  input  wire [WIDTH-1:0] wake_clear,
  output reg  [WIDTH-1:0] wake_flag_q,
  output reg              wake_irq_q
);
  // ----------------------------------------------------------------
  // falling edge capture, set wins over clear
  // ----------------------------------------------------------------
  reg  [WIDTH-1:0] prev_q;
  wire [WIDTH-1:0] hit;
  wire [WIDTH-1:0] flag_d;

  assign hit    = prev_q & ~pin_in & digital_en & wake_en;
  assign flag_d = (wake_flag_q & ~wake_clear) | hit;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q      <= {WIDTH{1'b1}};
      wake_flag_q <= {WIDTH{1'b0}};
      wake_irq_q  <= 1'b0;
    end else begin
      prev_q      <= pin_in;
      wake_flag_q <= flag_d;
      wake_irq_q  <= |flag_d;
    end
  end
endmodule // wake_detect

//--- testbench/port_pin_function_mux_monitor.sv
// port-level assertion checker for the pin function multiplexer
module port_pin_function_mux_monitor (
  input wire        sys_clk,
  input wire        sys_rst,
  input wire        maskable_int_pin_n,
  input wire        nonmaskable_int_pin_n,
  input wire        cpu_clear_i_mask,
  input wire        port_e_in_q,
  input wire        port_e_in0_q,
  input wire        maskable_int_req_q,
  input wire        nonmaskable_int_req_q,
  input wire        i_mask_q,
  input wire        x_mask_q,
  input wire        port_k_pullup_enable_wr,
  input wire        port_k_pullup_enable_in,
  input wire        port_e_pullup_q,
  input wire [7:0]  port_k_pullup_q,
  input wire        expanded_mode,
  input wire        port_k_emulation_enable,
  input wire        emulation_chip_select_n,
  input wire        external_chip_select_n,
  input wire [19:14] extended_address,
  input wire [7:0]  port_k_in,
  input wire [7:0]  port_k_out_q,
  input wire [7:0]  port_k_oe_q,
  input wire        onchip_rom_enable_q,
  input wire [7:0]  port_m_oe_q,
  input wire [7:0]  port_m_out_q,
  input wire        uart_two_tx_enable,
  input wire        uart_two_transmit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence emul_on;
    expanded_mode && port_k_emulation_enable;
  endsequence
  sequence k_off_wr;
    port_k_pullup_enable_wr && !port_k_pullup_enable_in;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_PORT_E_FOLLOW: assert property (!$past(sys_rst) |-> port_e_in_q == $past(maskable_int_pin_n)
    && port_e_in0_q == $past(nonmaskable_int_pin_n)) else $error("port e level not followed");
  AST_IRQ_CAUSE: assert property ($rose(maskable_int_req_q)
    |-> !$past(maskable_int_pin_n) && !$past(i_mask_q)) else $error("maskable request uncaused");
  AST_NONMASKABLE_INT_PIN_LEVEL: assert property (!$past(sys_rst) |-> nonmaskable_int_req_q ==
    (!$past(nonmaskable_int_pin_n) && !$past(x_mask_q))) else $error("nonmaskable request wrong");
  AST_I_MASK_CLEAR: assert property (cpu_clear_i_mask |=> !i_mask_q)
    else $error("i mask not cleared");
  AST_MASK_STICKY: assert property (!$past(sys_rst) |-> !$rose(i_mask_q) && !$rose(x_mask_q))
    else $error("mask set outside reset");
  AST_RESET_STATE: assert property ($past(sys_rst) |-> port_e_pullup_q && i_mask_q && x_mask_q
    && port_k_pullup_q == 8'hff && port_m_oe_q == 8'h00) else $error("bad state after reset");
  AST_K_PULLUP_OFF: assert property (k_off_wr |-> ##[1:2] port_k_pullup_q == 8'h00)
    else $error("port k pull-ups not off");
  AST_ROM_LATCH: assert property ($past(sys_rst) |=> onchip_rom_enable_q ==
    ($past(expanded_mode) && $past(port_k_in[7]))) else $error("rom enable not latched");
  AST_K_EMULATION: assert property (emul_on |=> port_k_oe_q == 8'hff
    && port_k_out_q == {$past(emulation_chip_select_n), $past(external_chip_select_n),
    $past(extended_address)}) else $error("port k emulation mapping wrong");
  AST_UART_TX: assert property (uart_two_tx_enable |=> port_m_oe_q[5]
    && port_m_out_q[5] == $past(uart_two_transmit)) else $error("uart transmit not on pin");
endmodule // port_pin_function_mux_monitor

//--- testbench/board_model.sv
// board side of port k: pin level from drive, external source and pull-up
module board_model (
  input  wire       clk,
  input  wire [7:0] drv,
  input  wire [7:0] oe,
  input  wire [7:0] pu,
  input  wire [7:0] ext,
  input  wire [7:0] ext_en,
  output logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog_q = 1'b0;
  // floating pins wander so an unknown never settles to a lucky value
  always @(posedge clk) tog_q <= ~tog_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = oe[i] ? drv[i] : ext_en[i] ? ext[i] : pu[i] ? 1'b1 : tog_q;
    end
  end
endmodule // board_model

//--- testbench/port_pin_function_mux_tb.sv
// self-checking bench for the pin function multiplexer
module port_pin_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic sys_clk = 0, sys_rst = 1, maskable_int_pin_n = 1, nonmaskable_int_pin_n = 1;
  logic edge_trigger_select_wr = 0, edge_trigger_select_in = 0, maskable_int_enable_wr = 0;
  logic maskable_int_enable_in = 0, cpu_clear_i_mask = 0, cpu_clear_x_mask = 0;
  logic port_e_pullup_enable_wr = 0, port_e_pullup_enable_in = 0, port_k_pullup_enable_wr = 0;
  logic port_k_pullup_enable_in = 0, expanded_mode = 1, port_k_emulation_enable = 0;
  logic emulation_chip_select_n = 1, external_chip_select_n = 1, i2c_enable = 0;
  logic i2c_scl_oe = 1, i2c_sda_oe = 0, uart_two_tx_enable = 0, uart_two_transmit = 1;
  logic uart_two_rx_enable = 0, dac_one_enable = 0, dac_two_enable = 0;
  logic fault_pwm_unit_enable = 0, current_status_enable = 0, fault_input_enable = 0;
  logic [19:14] extended_address = 6'h00;
  logic [7:0]  port_k_data = 8'h00, port_k_dir = 8'h00, k_ext = 8'h00, k_ext_en = 8'h00;
  logic [7:0]  port_m_in = 8'h00, port_m_data = 8'h55, port_m_dir = 8'h00;
  logic [15:0] port_ad_in = 16'hffff, port_ad_digital_en = 16'h0000;
  logic [15:0] keypad_wakeup_analog_port_en = 16'h0000, keypad_wakeup_clear = 16'h0000;
  logic [2:0]  fault_pwm_pair_enable = 3'h0;
  logic [5:0]  fault_pwm_outputs = 6'h2a, port_p_data = 6'h00, port_p_dir = 6'h00;
  logic [6:0]  port_q_in = 7'h00, port_q_data = 7'h00, port_q_dir = 7'h00;
  logic port_e_in_q, port_e_in0_q, maskable_int_req_q, nonmaskable_int_req_q, i_mask_q;
  logic x_mask_q, port_e_pullup_q, onchip_rom_enable_q, keypad_wakeup_irq, i2c_scl_in_q;
  logic i2c_sda_in_q, uart_two_receive_q, dac_output_one_sel_q, dac_output_two_sel_q;
  logic [7:0]  port_k_in, port_k_pullup_q, port_k_out_q, port_k_oe_q, port_k_read_q;
  logic [7:0]  port_m_out_q, port_m_oe_q;
  logic [15:0] keypad_wakeup_flag;
  logic [5:0]  port_p_out_q, port_p_oe_q;
  logic [6:0]  port_q_out_q, port_q_oe_q;
  logic [3:0]  fault_inputs_q;
  logic [2:0]  current_status_inputs_q;
  int          num_errors = 0, n_compared = 0;
  // enables {i2c, tx, rx, dac1, dac2} beside the expected port m enables
  logic [12:0] rows [7] = '{13'h00ff, 13'h10bf, 13'h08ff, 13'h04ef, 13'h02fd, 13'h01fe, 13'h1fac};

  port_pin_function_mux u_dut (.*);
  board_model u_board (.clk(sys_clk), .drv(port_k_out_q), .oe(port_k_oe_q),
    .pu(port_k_pullup_q), .ext(k_ext), .ext_en(k_ext_en), .pin(port_k_in));

  always #25 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    step(4);
    sys_rst = 0;
    step(1);
    chk("rom_hi", onchip_rom_enable_q, 1);
    chk("pullups", {port_e_pullup_q, port_k_pullup_q}, 9'h1ff);
    chk("masks", {i_mask_q, x_mask_q}, 2'h3);
    chk("oe_mpq", {port_m_oe_q, port_p_oe_q, port_q_oe_q}, 0);
    chk("periph_idle", {i2c_scl_in_q, i2c_sda_in_q, uart_two_receive_q}, 3'h7);
    chk("dac_idle", {dac_output_one_sel_q, dac_output_two_sel_q}, 0);
    chk("k_read", port_k_read_q, 8'hff);
    port_m_dir = 8'hff;
    foreach (rows[r]) begin
      {i2c_enable, uart_two_tx_enable, uart_two_rx_enable, dac_one_enable, dac_two_enable}
        = rows[r][12:8];
      step(1);
      chk("port_m_oe", port_m_oe_q, rows[r][7:0]);
    end
    chk("periph_in", {i2c_scl_in_q, i2c_sda_in_q, uart_two_receive_q}, 3'h0);
    chk("dac_sel", {dac_output_one_sel_q, dac_output_two_sel_q}, 2'h3);
    chk("port_m_out", port_m_out_q, 8'h35);
    maskable_int_pin_n = 0;
    step(1);
    chk("irq_masked", maskable_int_req_q, 0);
    pulse(cpu_clear_i_mask);
    step(1);
    chk("irq_level", maskable_int_req_q, 1);
    step(2);
    chk("irq_hold", maskable_int_req_q, 1);
    chk("pin1_read", port_e_in_q, 0);
    edge_trigger_select_in = 1;
    pulse(edge_trigger_select_wr);
    maskable_int_pin_n = 1;
    step(2);
    maskable_int_pin_n = 0;
    step(1);
    chk("irq_edge", maskable_int_req_q, 1);
    step(1);
    chk("irq_edge_end", maskable_int_req_q, 0);
    pulse(maskable_int_enable_wr);
    maskable_int_pin_n = 1;
    step(1);
    maskable_int_pin_n = 0;
    step(1);
    chk("irq_off", maskable_int_req_q, 0);
    nonmaskable_int_pin_n = 0;
    step(1);
    chk("nonmaskable_int_pin_masked", nonmaskable_int_req_q, 0);
    pulse(cpu_clear_x_mask);
    step(1);
    chk("nonmaskable_int_pin_level", {nonmaskable_int_req_q, port_e_in0_q}, 2'h2);
    {port_e_pullup_enable_wr, port_k_pullup_enable_wr} = 2'h3;
    step(1);
    {port_e_pullup_enable_wr, port_k_pullup_enable_wr} = 2'h0;
    step(2);
    chk("pullups_off", {port_e_pullup_q, port_k_pullup_q}, 0);
    port_k_emulation_enable = 1;
    emulation_chip_select_n = 0;
    extended_address = 6'h2d;
    step(1);
    chk("port_k", {port_k_oe_q, port_k_out_q}, 16'hff6d);
    step(1);
    port_k_emulation_enable = 0;
    k_ext_en = 8'h80;
    sys_rst = 1;
    step(4);
    sys_rst = 0;
    step(1);
    chk("rom_lo", {onchip_rom_enable_q, port_e_pullup_q}, 2'h1);
    chk("k_read_lo", port_k_read_q, 8'h7f);
    port_ad_digital_en[3] = 1;
    keypad_wakeup_analog_port_en[3] = 1;
    step(2);
    port_ad_in[3] = 0;
    for (int i = 0; i < 8 && keypad_wakeup_irq !== 1'b1; i++) step(1);
    chk("wake", {keypad_wakeup_irq, keypad_wakeup_flag}, 17'h10008);
    keypad_wakeup_clear[3] = 1'b1;
    step(1);
    keypad_wakeup_clear[3] = 1'b0;
    step(2);
    chk("wake_clr", {keypad_wakeup_irq, keypad_wakeup_flag}, 0);
    fault_pwm_unit_enable = 1;
    fault_pwm_pair_enable = 3'h2;
    step(1);
    chk("pwm_pair", {port_p_oe_q, port_p_out_q[3:2]}, 8'h32);
    fault_pwm_pair_enable = 3'h7;
    step(1);
    chk("pwm_all", {port_p_oe_q, port_p_out_q}, 12'hfea);
    port_q_data = 7'h33;
    {current_status_enable, fault_input_enable, port_q_dir, port_q_in} = 16'hff5a;
    step(1);
    chk("q_status", {current_status_inputs_q, fault_inputs_q}, 7'h5a);
    chk("q_oe", port_q_oe_q, 0);
    chk("q_out", port_q_out_q, 7'h33);
    close_out();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end
endmodule // port_pin_function_mux_tb

bind port_pin_function_mux port_pin_function_mux_monitor u_mon (.*);
